// >>> lgoe_lock_gated_output_enable.sv
// Lock-gated clock output enables with their configuration registers
`timescale 1ns/1ps

// What this block does
// - Gating bit clear (default): output enable ignores the lock indication.
// - Gating bit set: output enabled, without clock, only while lock is high.
// - Low gating register bits six to zero gate outputs six to zero alike.
// - Output ten has its own gating bit, behaving like output seven's.
// - High gating register: outputs eight to eleven, bits seven to four unused.
// - Output ten and eleven control registers share output zero's layout.
module lgoe_lock_gated_output_enable #(
	parameter int NUM_OUT = lgoe_pkg::LGOE_NUM_OUT
) (
	// Clock and reset
	input  logic                             ref_clk_in,
	input  logic                             reset_in,
	// Register access from the serial control port
	input  logic [lgoe_pkg::LGOE_ADDR_W-1:0] reg_addr_in,
	input  logic                             reg_write_in,
	input  logic [lgoe_pkg::LGOE_DATA_W-1:0] reg_wdata_in,
	output logic [lgoe_pkg::LGOE_DATA_W-1:0] reg_rdata_out,
	// Lock indication and other power-down settings
	input  logic                             current_source_lock_indication_in,
	input  logic [NUM_OUT-1:0]               power_down_in,
	// Output enables and per-output control
	output logic [NUM_OUT-1:0]               output_enable_out,
	output logic [lgoe_pkg::LGOE_DATA_W-1:0] output_ten_control_out,
	output logic [lgoe_pkg::LGOE_DATA_W-1:0] output_eleven_control_out
);
	import lgoe_pkg::*;

	logic [7:0]  lock_gate_outputs_low_q;
	logic [3:0]  lock_gate_outputs_high_q;
	logic [7:0]  output_ten_control_q;
	logic [7:0]  output_eleven_control_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic [11:0] gate_all;
	logic        lock;

	function automatic logic hit(input logic [9:0] ofs);
		hit = reg_write_in && (reg_addr_in == ofs);
	endfunction

	assign gate_all = {lock_gate_outputs_high_q, lock_gate_outputs_low_q};
	assign lock     = current_source_lock_indication_in;

	// Gating register, low byte
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			lock_gate_outputs_low_q <= LGOE_RST_GATE_LOW;
		end else if (hit(LGOE_OFS_GATE_LOW)) begin
			lock_gate_outputs_low_q <= reg_wdata_in;
		end
	end

	// Gating register, high byte; upper nibble is not stored
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			lock_gate_outputs_high_q <= LGOE_RST_GATE_HIGH;
		end else if (hit(LGOE_OFS_GATE_HIGH)) begin
			lock_gate_outputs_high_q <= reg_wdata_in[3:0];
		end
	end

	// Output ten and eleven control; fields decoded by the driver logic
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			output_ten_control_q    <= LGOE_RST_CTRL;
			output_eleven_control_q <= LGOE_RST_CTRL;
		end else begin
			if (hit(LGOE_OFS_CTRL_TEN)) begin
				output_ten_control_q <= reg_wdata_in;
			end
			if (hit(LGOE_OFS_CTRL_ELEVEN)) begin
				output_eleven_control_q <= reg_wdata_in;
			end
		end
	end

	// Read data; unmapped addresses read as zero
	always_comb begin
		case (reg_addr_in)
			LGOE_OFS_CTRL_TEN:    rdata_d = output_ten_control_q;
			LGOE_OFS_GATE_LOW:    rdata_d = lock_gate_outputs_low_q;
			LGOE_OFS_GATE_HIGH:   rdata_d = {4'h0, lock_gate_outputs_high_q};
			LGOE_OFS_CTRL_ELEVEN: rdata_d = output_eleven_control_q;
			default:              rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_out             = rdata_q;
	assign output_ten_control_out    = output_ten_control_q;
	assign output_eleven_control_out = output_eleven_control_q;

	// Combinational on purpose: lock must gate the output without a clock
	// edge, so a lock loss shuts the output at once. Relies on software
	// having selected the current-source lock detect method.
	always_comb begin
		for (int i = 0; i < NUM_OUT; i++) begin
			output_enable_out[i] = !power_down_in[i] &&
				(!gate_all[i] || lock);
		end
	end

	property p_seven_free;
		@(posedge ref_clk_in) disable iff (reset_in)
		(!gate_all[LGOE_BIT_SEVEN] && !power_down_in[LGOE_BIT_SEVEN])
			|-> output_enable_out[LGOE_BIT_SEVEN];
	endproperty
	a_seven_free: assert property (p_seven_free)
		else $error("Ungated output seven not enabled");

	property p_seven_gated;
		@(posedge ref_clk_in) disable iff (reset_in)
		gate_all[LGOE_BIT_SEVEN] |-> (output_enable_out[LGOE_BIT_SEVEN] ==
			(lock && !power_down_in[LGOE_BIT_SEVEN]));
	endproperty
	a_seven_gated: assert property (p_seven_gated)
		else $error("Gated output seven does not follow lock");

	property p_low_write;
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_write_in && reg_addr_in == LGOE_OFS_GATE_LOW)
			##1 (lock == 1'b0)
			|-> (output_enable_out[6:0] == (~power_down_in[6:0] &
			~$past(reg_wdata_in[6:0])));
	endproperty
	a_low_write: assert property (p_low_write)
		else $error("Low gating bits do not gate outputs after write");

	property p_ten_gated;
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_write_in && reg_addr_in == LGOE_OFS_GATE_HIGH &&
			reg_wdata_in[2]) ##1 !lock
			|-> !output_enable_out[LGOE_BIT_TEN];
	endproperty
	a_ten_gated: assert property (p_ten_gated)
		else $error("Output ten enabled without lock while gated");

	property p_high_unused;
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_addr_in == LGOE_OFS_GATE_HIGH) |=> (reg_rdata_out[7:4] == 4'h0);
	endproperty
	a_high_unused: assert property (p_high_unused)
		else $error("Unused gating bits read nonzero");

	property p_eleven_bit;
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_write_in && reg_addr_in == LGOE_OFS_GATE_HIGH) |=>
			(gate_all[LGOE_BIT_ELEVEN] == $past(reg_wdata_in[3]));
	endproperty
	a_eleven_bit: assert property (p_eleven_bit)
		else $error("Output eleven gating bit not at bit three");

	// Strobes spelled out: a function body here would not be sampled
	property p_ctrl_ten;
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_write_in && reg_addr_in == LGOE_OFS_CTRL_TEN) |=>
			(output_ten_control_out == $past(reg_wdata_in));
	endproperty
	a_ctrl_ten: assert property (p_ctrl_ten)
		else $error("Output ten control not stored");

	property p_ctrl_eleven;
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_write_in && reg_addr_in == LGOE_OFS_CTRL_ELEVEN) |=>
			(output_eleven_control_out == $past(reg_wdata_in));
	endproperty
	a_ctrl_eleven: assert property (p_ctrl_eleven)
		else $error("Output eleven control not stored");

	property p_reset_clear;
		@(posedge ref_clk_in)
		reset_in |=> (gate_all == 12'h000);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("Gating bits not cleared by reset");

	// Whole-vector enable and low gating register checks, so a slip in one bit index is caught too; then the output ten gating bit
	property p_ungated_all;
		@(posedge ref_clk_in) disable iff (reset_in)
		((~gate_all & ~power_down_in & ~output_enable_out) == '0);
	endproperty
	a_ungated_all: assert property (p_ungated_all)
		else $error("Ungated output not enabled");

	property p_lock_all_on;
		@(posedge ref_clk_in) disable iff (reset_in)
		lock |-> (output_enable_out == ~power_down_in);
	endproperty
	a_lock_all_on: assert property (p_lock_all_on)
		else $error("Output disabled while locked and powered");

	property p_no_lock_gated;
		@(posedge ref_clk_in) disable iff (reset_in)
		!lock |-> ((output_enable_out & gate_all) == '0);
	endproperty
	a_no_lock_gated: assert property (p_no_lock_gated)
		else $error("Gated output enabled without lock");

	property p_power_down_wins;
		@(posedge ref_clk_in) disable iff (reset_in)
		((output_enable_out & power_down_in) == '0);
	endproperty
	a_power_down_wins: assert property (p_power_down_wins)
		else $error("Powered-down output enabled");

	property p_low_bits_stored;
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_write_in && reg_addr_in == LGOE_OFS_GATE_LOW) |=>
			(gate_all[LGOE_DATA_W-1:0] == $past(reg_wdata_in));
	endproperty
	a_low_bits_stored: assert property (p_low_bits_stored)
		else $error("Low gating register not stored");

	property p_ten_bit;
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_write_in && reg_addr_in == LGOE_OFS_GATE_HIGH) |=>
			(gate_all[LGOE_BIT_TEN] ==
			$past(reg_wdata_in[LGOE_BIT_TEN-LGOE_DATA_W]));
	endproperty
	a_ten_bit: assert property (p_ten_bit)
		else $error("Output ten gating bit not at bit two");

endmodule // lgoe_lock_gated_output_enable

// >>> lgoe_pkg.sv
// Register map and reset values of the lock-gated output enable block
package lgoe_pkg;
	localparam int            LGOE_ADDR_W          = 10;
	localparam int            LGOE_DATA_W          = 8;
	localparam int            LGOE_NUM_OUT         = 12;
	localparam logic [9:0]    LGOE_OFS_CTRL_TEN    = 10'h0fa;
	localparam logic [9:0]    LGOE_OFS_GATE_LOW    = 10'h0fc;
	localparam logic [9:0]    LGOE_OFS_GATE_HIGH   = 10'h0fd;
	localparam logic [9:0]    LGOE_OFS_CTRL_ELEVEN = 10'h0fe;
	localparam logic [7:0]    LGOE_RST_GATE_LOW    = 8'h00;
	localparam logic [3:0]    LGOE_RST_GATE_HIGH   = 4'h0;
	localparam logic [7:0]    LGOE_RST_CTRL        = 8'h00;
	localparam int            LGOE_GATE_HIGH_W     = 4;
	localparam int            LGOE_BIT_SEVEN       = 7;
	localparam int            LGOE_BIT_TEN         = 10;
	localparam int            LGOE_BIT_ELEVEN      = 11;
endpackage

// >>> lgoe_lock_gated_output_enable_bench.sv
// Self-checking bench of the lock-gated output enable block
`timescale 1ns/1ps
module lgoe_lock_gated_output_enable_bench;
	import lgoe_pkg::*;
	logic        clk = 0, rst = 1, wr = 0, lock = 0;
	logic [9:0]  addr = 0;
	logic [7:0]  wd = 0, rd, c10, c11, gl = 0, m10 = 0, m11 = 0;
	logic [3:0]  gh = 0;
	logic [11:0] pd = 0, en;
	logic [31:0] rs = 32'h0099;
	logic [9:0]  ofs [4] = '{LGOE_OFS_CTRL_TEN, LGOE_OFS_GATE_LOW,
		LGOE_OFS_GATE_HIGH, LGOE_OFS_CTRL_ELEVEN};
	int          errors = 0, checks_done = 0;
	lgoe_lock_gated_output_enable u_lgoe_lock_gated_output_enable (
		.ref_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
		.reg_write_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rd),
		.current_source_lock_indication_in(lock), .power_down_in(pd),
		.output_enable_out(en), .output_ten_control_out(c10),
		.output_eleven_control_out(c11));
	initial forever #2 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Power-down wins over lock; an ungated output ignores lock
	function automatic logic [11:0] exp_en();
		return ~pd & (~{gh, gl} | {12{lock}});
	endfunction
	function automatic logic [7:0] exp_rd(input logic [9:0] a);
		case (a)
			LGOE_OFS_CTRL_TEN:    return m10;
			LGOE_OFS_GATE_LOW:    return gl;
			LGOE_OFS_GATE_HIGH:   return {4'h0, gh};
			LGOE_OFS_CTRL_ELEVEN: return m11;
			default:              return 8'h00;
		endcase
	endfunction
	task automatic cmp_en(logic [11:0] e, logic [11:0] g);
		checks_done++;
		if (e !== g) begin
			errors++;
			$display("mismatch enable expected %h seen %h", e, g);
		end
	endtask
	task automatic cmp_rd(logic [9:0] a, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (e !== g) begin
			errors++;
			$display("mismatch read_%h expected %h seen %h", a, e, g);
		end
	endtask
	task automatic cmp_ctrl(string n, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (e !== g) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic peek(logic [9:0] a);
		@(posedge clk);
		addr <= a;
		@(posedge clk);
		#1 cmp_rd(a, exp_rd(a), rd);
	endtask
	task automatic put(logic [9:0] a, logic [7:0] d, logic l, logic [11:0] p);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1;
		lock <= l; // Current-source lock with comparator on
		pd <= p;
		@(posedge clk);
		wr <= 0;
		#1;
		case (a)
			LGOE_OFS_CTRL_TEN:    m10 = d;
			LGOE_OFS_GATE_LOW:    gl = d;
			LGOE_OFS_GATE_HIGH:   gh = d[3:0];
			LGOE_OFS_CTRL_ELEVEN: m11 = d;
			default:              ;
		endcase
		cmp_en(exp_en(), en);
		cmp_ctrl("ctrl_ten", m10, c10);
		cmp_ctrl("ctrl_eleven", m11, c11);
		@(posedge clk);
		#1 cmp_rd(a, exp_rd(a), rd);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#40000;
		errors++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 4; i++) peek(ofs[i]);
		cmp_en(exp_en(), en);
		put(LGOE_OFS_GATE_LOW, 8'h80, 1'b1, 12'h000);
		// Lock drop must reach the gated output with no clock edge
		@(posedge clk);
		lock <= 0;
		#1 cmp_en(exp_en(), en);
		put(LGOE_OFS_GATE_HIGH, 8'hff, 1'b0, 12'h000);
		put(LGOE_OFS_GATE_LOW, 8'h7f, 1'b1, 12'h081);
		put(10'h0fb, 8'h55, 1'b0, 12'h000);
		for (int i = 0; i < 300; i++) begin
			rs = xs(rs);
			put(rs[2] ? ofs[rs[1:0]] : rs[31:22], rs[15:8], rs[3],
				rs[27:16] & {12{rs[4]}});
		end
		// Reset in mid-run must clear every gating bit and control byte
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		gl  = LGOE_RST_GATE_LOW;
		gh  = LGOE_RST_GATE_HIGH;
		m10 = LGOE_RST_CTRL;
		m11 = LGOE_RST_CTRL;
		#1 cmp_en(exp_en(), en);
		for (int i = 0; i < 4; i++) peek(ofs[i]);
		close_out();
	end
endmodule // lgoe_lock_gated_output_enable_bench
